// >>> clock_source_select_startup.sv
// Clock source decode, start-up sequencing, prescale and domain gating.
// Assumes oscillators deliver one-cycle ticks synchronous to clk, fuses
// are static, and the sleep controller pulses sleep_req and wake_evt.
`timescale 1ns/1ps

// Summary of operation
// - Decode source fuses into four clock options
// - Reserved source codes select no clock
// - Fuse value one unprogrammed, zero programmed
// - Wake from deep sleep counts source cycles
// - Reset adds 4,096 or 65,536 watchdog cycles
// - RC: 6 wake, 14 plus watchdog reset
// - RC start-up code 11 is reserved
// - Factory default RC, code 10, divide-by-eight
// - Programmed divide fuse prescales clock by eight
// - Reset copies calibration byte into trim register
// - Watchdog and time-out use watchdog oscillator
// - Core clock halts; core does nothing then
// - Peripheral clock; async interrupt detect when halted
// - Serial start detection asynchronous while halted
// - Program store clock follows core clock
// - Async timer domain runs during sleep
// - Converter clock runs in idle and noise reduction sleep
// - Sleep mode gates unused clock domains
module clock_source_select_startup
    import clock_startup_pkg::*;
#(
    parameter logic [16:0] WDT_LONG_CNT = 17'h10000,     // 65,536 watchdog cycles
    parameter logic [16:0] XTAL_WAKE_LONG = 17'h04000,   // 16K source cycles
    parameter logic [16:0] LFXTAL_WAKE_CK = 17'h00400,   // Plain default
    parameter logic [16:0] EXT_WAKE_CK = 17'h00006       // Plain default
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire fuse_cfg_s fuses,
    input wire logic [7:0] calib_byte,
    input wire osc_ticks_s osc_ticks,
    input wire logic wdt_osc_tick,
    input wire logic async_osc_tick,
    input wire logic sleep_req,
    input wire logic [2:0] sleep_mode,
    input wire logic wake_evt,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output clk_en_s clk_en,
    output logic watchdog_timer_clock_en,
    output logic async_detect_en,
    output logic exec_hold,
    output logic [7:0] oscillator_trim_register
);

    // ==========================================================
    // Sequencer state
    typedef enum logic [6:0] {
        ST_LOAD = 7'h01,      // Catch fuses and calibration after reset
        ST_SRC_WAIT = 7'h02,  // Fixed source-cycle part of reset delay
        ST_WDT_WAIT = 7'h04,  // Watchdog-timed part of reset delay
        ST_RUN = 7'h08,       // Normal execution
        ST_SLEEP = 7'h10,     // Asleep in sleep_mode_reg
        ST_WAKE = 7'h20,      // Oscillator settling after deep sleep
        ST_BAD = 7'h40        // Reserved configuration, only the watchdog clock runs
    } seq_state_e;

    seq_state_e state_reg;
    fuse_cfg_s fuse_reg;          // Fuse snapshot taken after reset release
    logic [16:0] cnt_reg;         // Shared start-up counter
    logic [2:0] div_reg;          // Divide-by-eight phase
    logic [2:0] sleep_mode_reg;   // Mode latched at sleep entry

    // Decoded configuration
    logic src_tick;               // Tick of the selected source
    logic cfg_bad;                // Reserved source or start-up code
    logic [16:0] wake_ck;         // Source cycles to wait after deep sleep
    wdt_sel_e wdt_sel;            // Watchdog part of the reset delay
    logic [16:0] wdt_target;
    logic div8_on;
    logic sys_tick;               // Prescaled system clock enable
    logic deep_mode;              // Mode that stops the main oscillator

    // ==========================================================
    // Source and start-up decode
    // A reserved source code gives no tick; any reserved code ends in ST_BAD, where only the watchdog clock enable runs.
    always_comb
    begin
        src_tick = 1'b0;
        cfg_bad = 1'b0;
        wake_ck = RC_WAKE_CK;
        wdt_sel = WDT_NONE;
        if (fuse_reg.src_sel[SRC_XTAL_BIT])
        begin
            // Crystal / resonator: start-up bit and code pick the timing
            src_tick = osc_ticks.xtal;
            case ({fuse_reg.src_sel[SRC_CK0_BIT], fuse_reg.startup_time_select_fuses})
                3'h0: begin wake_ck = XTAL_WAKE_SHORT; wdt_sel = WDT_SHORT; end
                3'h1: begin wake_ck = XTAL_WAKE_SHORT; wdt_sel = WDT_LONG; end
                3'h2: begin wake_ck = XTAL_WAKE_MID; wdt_sel = WDT_NONE; end
                3'h3: begin wake_ck = XTAL_WAKE_MID; wdt_sel = WDT_SHORT; end
                3'h4: begin wake_ck = XTAL_WAKE_MID; wdt_sel = WDT_LONG; end
                3'h5: begin wake_ck = XTAL_WAKE_LONG; wdt_sel = WDT_NONE; end
                3'h6: begin wake_ck = XTAL_WAKE_LONG; wdt_sel = WDT_SHORT; end
                default: begin wake_ck = XTAL_WAKE_LONG; wdt_sel = WDT_LONG; end
            endcase
        end
        else
        begin
            // RC, low-frequency and external share the two-bit timing code
            case (fuse_reg.startup_time_select_fuses)
                2'h0: wdt_sel = WDT_NONE;
                2'h1: wdt_sel = WDT_SHORT;
                2'h2: wdt_sel = WDT_LONG;
                default: cfg_bad = 1'b1;
            endcase
            case (fuse_reg.src_sel)
                SRC_RC: begin src_tick = osc_ticks.rc; wake_ck = RC_WAKE_CK; end
                SRC_LF_LO, SRC_LF_HI:
                begin
                    src_tick = osc_ticks.lfxtal;
                    wake_ck = LFXTAL_WAKE_CK;
                end
                SRC_EXT: begin src_tick = osc_ticks.ext; wake_ck = EXT_WAKE_CK; end
                default: cfg_bad = 1'b1;
            endcase
        end
    end

    // Watchdog count for the reset delay
    always_comb
    begin
        case (wdt_sel)
            WDT_SHORT: wdt_target = WDT_SHORT_CNT;
            WDT_LONG: wdt_target = WDT_LONG_CNT;
            default: wdt_target = WDT_SHORT_CNT;
        endcase
    end

    // Programmed divide fuse reads as 0
    assign div8_on = (fuse_reg.div8 == FUSE_PROGRAMMED);
    assign sys_tick = src_tick && (!div8_on || div_reg == DIV8_LAST);
    assign deep_mode = (sleep_mode_reg == SLP_PWR_DOWN) || (sleep_mode_reg == SLP_PWR_SAVE)
        || (sleep_mode_reg == SLP_STANDBY);

    // ==========================================================
    // Fuse snapshot: straps are caught on the first clock after release,
    // never through the asynchronous reset path.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Reset image is the unprogrammed state of every fuse
            fuse_reg <= '1;
        end
        else if (state_reg == ST_LOAD)
        begin
            fuse_reg <= fuses;
        end
    end

    // ==========================================================
    // Start-up sequencer and counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_LOAD;
            cnt_reg <= '0;
            sleep_mode_reg <= SLP_IDLE;
        end
        else
        begin
            case (state_reg)
                ST_LOAD:
                begin
                    // Counter cleared on every restart
                    cnt_reg <= '0;
                    state_reg <= ST_SRC_WAIT;
                end
                ST_SRC_WAIT:
                begin
                    if (cfg_bad)
                    begin
                        state_reg <= ST_BAD;
                    end
                    else if (src_tick)
                    begin
                        if (cnt_reg == RESET_SRC_CK - 17'h00001)
                        begin
                            cnt_reg <= '0;
                            state_reg <= (wdt_sel == WDT_NONE) ? ST_RUN : ST_WDT_WAIT;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 17'h00001;
                        end
                    end
                end
                ST_WDT_WAIT:
                begin
                    // Timed from the watchdog oscillator whatever the source
                    if (wdt_osc_tick)
                    begin
                        if (cnt_reg == wdt_target - 17'h00001)
                        begin
                            cnt_reg <= '0;
                            state_reg <= ST_RUN;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 17'h00001;
                        end
                    end
                end
                ST_RUN:
                begin
                    if (sleep_req)
                    begin
                        sleep_mode_reg <= sleep_mode;
                        state_reg <= ST_SLEEP;
                    end
                end
                ST_SLEEP:
                begin
                    if (wake_evt)
                    begin
                        // Stopped oscillator must settle before execution
                        cnt_reg <= '0;
                        state_reg <= deep_mode ? ST_WAKE : ST_RUN;
                    end
                end
                ST_WAKE:
                begin
                    if (src_tick)
                    begin
                        if (cnt_reg == wake_ck - 17'h00001)
                        begin
                            cnt_reg <= '0;
                            state_reg <= ST_RUN;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 17'h00001;
                        end
                    end
                end
                ST_BAD:
                begin
                    // Only a reset leaves a reserved configuration
                    state_reg <= ST_BAD;
                end
                default:
                begin
                    state_reg <= ST_LOAD;
                end
            endcase
        end
    end

    // ==========================================================
    // Divide-by-eight phase; restarts with the sequence so the first
    // system tick after reset is a full eight source cycles away
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= '0;
        end
        else if (state_reg == ST_LOAD)
        begin
            div_reg <= '0;
        end
        else if (src_tick)
        begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // ==========================================================
    // Domain gating. Domains receive registered tick enables rather than
    // gated clock edges, so no phase can ever be cut short.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_en <= '0;
            watchdog_timer_clock_en <= 1'b0;
            async_detect_en <= 1'b0;
            exec_hold <= 1'b1;
        end
        else
        begin
            // Core and program store only while executing
            clk_en.core <= sys_tick && (state_reg == ST_RUN);
            clk_en.pstore <= sys_tick && (state_reg == ST_RUN);
            // Peripherals keep running in idle
            clk_en.periph <= sys_tick && ((state_reg == ST_RUN)
                || (state_reg == ST_SLEEP && sleep_mode_reg == SLP_IDLE));
            // Converter keeps running in idle and noise reduction
            clk_en.conv <= sys_tick && ((state_reg == ST_RUN)
                || (state_reg == ST_SLEEP && (sleep_mode_reg == SLP_IDLE
                || sleep_mode_reg == SLP_ADC_NR)));
            // Async timer runs through every sleep mode once started
            clk_en.async_tmr <= async_osc_tick
                && (state_reg != ST_LOAD) && (state_reg != ST_BAD);
            watchdog_timer_clock_en <= wdt_osc_tick;
            // Async interrupt and serial start detection take over
            async_detect_en <= (state_reg == ST_SLEEP)
                && (sleep_mode_reg != SLP_IDLE);
            exec_hold <= (state_reg != ST_RUN);
        end
    end

    // ==========================================================
    // Oscillator trim: calibration copied during the reset sequence,
    // software may retune afterwards
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oscillator_trim_register <= TRIM_RESET;
        end
        else if (state_reg == ST_LOAD)
        begin
            oscillator_trim_register <= calib_byte;
        end
        else if (wr && addr == ADDR_TRIM)
        begin
            oscillator_trim_register <= wdata;
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= '0;
            if (rd)
            begin
                case (addr)
                    ADDR_TRIM: rdata <= oscillator_trim_register;
                    ADDR_STATUS:
                    begin
                        rdata[ST_RUN_BIT] <= (state_reg == ST_RUN);
                        rdata[ST_SLEEP_BIT] <= (state_reg == ST_SLEEP);
                        rdata[ST_BAD_BIT] <= (state_reg == ST_BAD);
                        rdata[ST_DIV8_BIT] <= div8_on;
                        rdata[ST_WAIT_BIT] <= (state_reg == ST_SRC_WAIT)
                            || (state_reg == ST_WDT_WAIT) || (state_reg == ST_WAKE);
                    end
                    ADDR_FUSES: rdata <= {1'b0, fuse_reg};
                    default: rdata <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // Assertions
    a_core_halted_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg != ST_RUN) |=> !clk_en.core)
        else $error("core clock enabled outside run");
    a_pstore_follows: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en.pstore == clk_en.core)
        else $error("program store clock differs from core clock");
    a_reserved_stops: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SRC_WAIT && cfg_bad) |=> (state_reg == ST_BAD) [*3])
        else $error("reserved configuration did not stop");
    a_src_wait_full: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SRC_WAIT && !cfg_bad && cnt_reg < RESET_SRC_CK - 17'h00001)
        |=> state_reg == ST_SRC_WAIT)
        else $error("reset delay left early");
    a_wdt_wait_done: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_WDT_WAIT && wdt_osc_tick && cnt_reg == wdt_target - 17'h00001)
        |=> state_reg == ST_RUN ##1 exec_hold == 1'b0)
        else $error("watchdog delay end not honoured");
    a_div8_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        (div8_on && clk_en.periph) |=> !clk_en.periph [*7])
        else $error("prescaled clock faster than one in eight");
    a_trim_loaded: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_LOAD) |=> oscillator_trim_register == $past(calib_byte))
        else $error("calibration byte not loaded");
    a_wdt_clock_free: assert property (@(posedge clk) disable iff (!rst_n)
        wdt_osc_tick |=> watchdog_timer_clock_en)
        else $error("watchdog clock missed a tick");
    a_async_detect_on: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && sleep_mode_reg != SLP_IDLE) |=> async_detect_en && !clk_en.periph)
        else $error("asynchronous detection not handed over");
    a_deep_wake_waits: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && wake_evt && deep_mode) |=> state_reg == ST_WAKE ##1 exec_hold)
        else $error("deep wake skipped oscillator settling");
    a_async_in_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && async_osc_tick) |=> clk_en.async_tmr)
        else $error("async timer stopped in sleep");

    c_reach_run: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_WDT_WAIT ##1 state_reg == ST_RUN);
    c_deep_wake: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_WAKE ##1 state_reg == ST_RUN);
    c_bad_config: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_BAD);
    c_adc_nr_conv: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_SLEEP && sleep_mode_reg == SLP_ADC_NR && clk_en.conv);

endmodule : clock_source_select_startup

// >>> clock_source_select_startup_bench.sv
// Self-checking bench for source decode, start-up timing and registers.
// Assumes osc_model feeds all ticks; the long watchdog count is cut to 20.
`timescale 1ns/1ps
module clock_source_select_startup_bench
    import clock_startup_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fuse_cfg_s fuses = '0;
    logic [7:0] calib_byte = 8'h00;
    osc_ticks_s osc_ticks;
    logic wdt_osc_tick, async_osc_tick, sleep_req = 1'b0, wake_evt = 1'b0;
    logic [2:0] sleep_mode = 3'h0;
    logic [3:0] addr = 4'h0;
    logic wr = 1'b0, rd = 1'b0, wdt_en, async_det, exec_hold;
    logic [7:0] wdata = 8'h00, rdata, trim, r, d;
    clk_en_s clk_en;
    int n_mismatch = 0, checked = 0, seed = 32'he0444889, n, n_core = 0, n0;
    // Reserved sources and the reserved RC start-up code
    fuse_cfg_s bad[5] = '{'{4'h3, 2'h0, 1'b1}, '{4'h1, 2'h0, 1'b1},
        '{4'h5, 2'h0, 1'b1}, '{4'h4, 2'h0, 1'b1}, '{4'h2, 2'h3, 1'b1}};
    always #4 clk = ~clk;
    always @(posedge clk) n_core += (clk_en.core === 1'b1);
    osc_model #(.PER(5)) osc (.clk(clk), .osc_ticks(osc_ticks),
        .wdt_osc_tick(wdt_osc_tick), .async_osc_tick(async_osc_tick));
    clock_source_select_startup #(.WDT_LONG_CNT(17'h00014)) uut (.clk(clk),
        .rst_n(rst_n), .fuses(fuses), .calib_byte(calib_byte), .osc_ticks(osc_ticks),
        .wdt_osc_tick(wdt_osc_tick), .async_osc_tick(async_osc_tick),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_evt(wake_evt),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clk_en(clk_en),
        .watchdog_timer_clock_en(wdt_en), .async_detect_en(async_det),
        .exec_hold(exec_hold), .oscillator_trim_register(trim));
    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic summarize;
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Strobes get a gap cycle so no signal is assigned twice in one step
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : reg_rd
    // Leaves the bench one edge after release (the load cycle), so the
    // first edge that the sequencer counts on is also the first one seen here
    task automatic do_reset(input fuse_cfg_s f);
        rst_n <= 1'b0;
        fuses <= f;
        calib_byte <= $random(seed);
        repeat (5) @(posedge clk);
        chk("reset hold", 8'h01, {7'h0, exec_hold});
        chk("reset trim", 8'h00, trim);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    // Counts source ticks seen while execution is held, bounded wait
    task automatic count_hold(output int c);
        int k;
        c = 0;
        k = 0;
        do
        begin
            @(posedge clk);
            c += (osc_ticks.rc && exec_hold === 1'b1);
            k++;
        end while (exec_hold !== 1'b0 && k < 3000);
    endtask : count_hold
    // ==========================================================
    // Scenarios
    initial
    begin
        do_reset('{4'h2, 2'h0, 1'b1});
        count_hold(n);
        chk("reset ticks", 8'h0e, n[7:0]);
        chk("trim load", calib_byte, trim);
        reg_rd(ADDR_STATUS, r);
        chk("status", 8'h01, r);
        reg_rd(ADDR_FUSES, r);
        chk("fuses", 8'h11, r);
        repeat (4)
        begin
            r = $random(seed);
            reg_wr(ADDR_TRIM, r);
            reg_wr(ADDR_STATUS, ~r);
            reg_rd(ADDR_TRIM, d);
            chk("trim", r, d);
        end
        reg_rd(4'h5, d);
        chk("unmapped", 8'h00, d);
        sleep_mode <= SLP_PWR_DOWN;
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (3) @(posedge clk);
        n0 = n_core;
        chk("async detect", 8'h01, {7'h0, async_det});
        repeat (40) @(posedge clk);
        chk("core gated", 8'h00, 8'(n_core - n0));
        wake_evt <= 1'b1;
        @(posedge clk);
        wake_evt <= 1'b0;
        count_hold(n);
        chk("wake ticks", 8'h06, n[7:0]);
        do_reset('{4'h2, 2'h2, 1'b0});
        count_hold(n);
        chk("default run", 8'h00, {7'h0, exec_hold});
        reg_rd(ADDR_STATUS, r);
        chk("div8 status", 8'h09, r);
        // External clock and low-frequency crystal use the same short reset delay
        do_reset('{SRC_EXT, 2'h0, 1'b1});
        count_hold(n);
        chk("ext ticks", 8'h0e, n[7:0]);
        do_reset('{SRC_LF_LO, 2'h0, 1'b1});
        count_hold(n);
        chk("lf ticks", 8'h0e, n[7:0]);
        foreach (bad[i])
        begin
            do_reset(bad[i]);
            repeat (60) @(posedge clk);
            reg_rd(ADDR_STATUS, r);
            chk("reserved", 8'h04, r & 8'h05);
        end
        summarize();
    end
    initial
    begin
        #(8 * 40000);
        n_mismatch++;
        summarize();
    end
endmodule : clock_source_select_startup_bench

// >>> clock_startup_pkg.sv
// Constants, types and encodings shared by the clock control block.
// Assumes fuse values are stable straps and oscillator activity arrives as
// one-cycle tick enables on the single system clock.
package clock_startup_pkg;

    // ==========================================================
    // Fuse encodings (a stored 1 is unprogrammed, 0 is programmed)
    localparam logic [3:0] SRC_RC = 4'h2;         // Internal RC oscillator
    localparam logic [3:0] SRC_EXT = 4'h0;        // External clock input
    localparam logic [3:0] SRC_LF_LO = 4'h6;      // Low-frequency crystal, low code
    localparam logic [3:0] SRC_LF_HI = 4'h7;      // Low-frequency crystal, high code
    localparam int SRC_XTAL_BIT = 3;              // Set in all crystal/resonator codes
    localparam int SRC_CK0_BIT = 0;               // Start-up bit inside crystal codes
    localparam logic [1:0] SUT_RESERVED = 2'h3;   // Reserved start-up code for RC/LF
    localparam logic FUSE_PROGRAMMED = 1'h0;      // Programmed fuse reads as 0

    // ==========================================================
    // Start-up counts (cycles of the named oscillator)
    localparam logic [16:0] RESET_SRC_CK = 17'h0000e;   // 14 source cycles
    localparam logic [16:0] RC_WAKE_CK = 17'h00006;     // 6 source cycles
    localparam logic [16:0] XTAL_WAKE_SHORT = 17'h00102;  // 258 source cycles
    localparam logic [16:0] XTAL_WAKE_MID = 17'h00400;    // 1K source cycles
    localparam logic [16:0] WDT_SHORT_CNT = 17'h01000;    // 4,096 watchdog cycles
    localparam logic [2:0] DIV8_LAST = 3'h7;              // Last phase of divide by 8

    // ==========================================================
    // Reset delay choice
    typedef enum logic [1:0] {WDT_NONE = 2'h0, WDT_SHORT = 2'h1, WDT_LONG = 2'h2} wdt_sel_e;

    // Sleep modes from the sleep controller
    localparam logic [2:0] SLP_IDLE = 3'h0;
    localparam logic [2:0] SLP_ADC_NR = 3'h1;
    localparam logic [2:0] SLP_PWR_DOWN = 3'h2;
    localparam logic [2:0] SLP_PWR_SAVE = 3'h3;
    localparam logic [2:0] SLP_STANDBY = 3'h6;

    // ==========================================================
    // Register map of the plain register port
    localparam logic [3:0] ADDR_TRIM = 4'h0;      // oscillator_trim_register, R/W
    localparam logic [3:0] ADDR_STATUS = 4'h1;    // Sequencer status, read only
    localparam logic [3:0] ADDR_FUSES = 4'h2;     // Latched fuse snapshot, read only
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam int ST_RUN_BIT = 0;                // Status: executing
    localparam int ST_SLEEP_BIT = 1;              // Status: asleep
    localparam int ST_BAD_BIT = 2;                // Status: reserved configuration
    localparam int ST_DIV8_BIT = 3;               // Status: prescale by 8 active
    localparam int ST_WAIT_BIT = 4;               // Status: start-up timing running

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [3:0] src_sel;     // clock_source_select_fuses
        logic [1:0] startup_time_select_fuses;         // startup_time_select_fuses
        logic div8;              // divide_by_eight_fuse
    } fuse_cfg_s;

    typedef struct packed {
        logic xtal;              // Crystal / resonator oscillator tick
        logic lfxtal;            // Low-frequency crystal tick
        logic rc;                // Internal RC oscillator tick
        logic ext;               // External clock input tick
    } osc_ticks_s;

    typedef struct packed {
        logic core;              // core_clock enable
        logic periph;            // peripheral_clock enable
        logic pstore;            // program_store_clock enable
        logic async_tmr;         // async_timer_clock enable
        logic conv;              // converter_clock enable
    } clk_en_s;

endpackage : clock_startup_pkg

// >>> osc_model.sv
// Oscillator model: source, watchdog and async oscillator ticks.
// Assumes one system clock; ticks are free-running one-cycle pulses.
`timescale 1ns/1ps
module osc_model
    import clock_startup_pkg::*;
#(
    parameter int PER = 5 // Source period in system cycles
)
(
    input wire logic clk,
    output osc_ticks_s osc_ticks,
    output logic wdt_osc_tick,
    output logic async_osc_tick
);
    // ==========================================================
    // Tick generation
    int ph = 0; // No reset: a real oscillator ignores the chip reset
    initial {osc_ticks, wdt_osc_tick, async_osc_tick} = '0;
    // Phases kept apart so the watchdog never ticks with the source
    always @(posedge clk)
    begin
        ph <= (ph + 1) % PER;
        osc_ticks <= {4{ph == 0}};
        wdt_osc_tick <= (ph == 2);
        async_osc_tick <= (ph == 3);
    end
endmodule : osc_model
